// file: event_step_sequencer_pkg.sv
// constants, register map and state type of the event step sequencer
package event_step_sequencer_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS  = 10_000_000;
  localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCAN_TIME_NS  = 1_000_000;
  localparam int SCAN_CYCLES   = (SCAN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_STEPS    = 16;
  localparam int NUM_OUTS     = 16;
  localparam int MAX_SETTING  = 9999;
  localparam int NUM_COUNTERS = 64;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int VAL_W        = 14;
  localparam int STEP_W       = 5;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TIMEBASE  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_LAST_STEP = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_OUT_MASK  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STEP_CNT  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_TICK_TMR  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_PRESET    = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CUR_STEP  = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_BASE_CTR  = 8'h24;
  localparam logic [1:0]        AREA_COUNTS    = 2'h1;
  localparam logic [1:0]        AREA_PATTERN   = 2'h2;
  localparam logic [1:0]        AREA_EVENT     = 2'h3;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_RET_BIT   = 1;
  localparam int EVT_EN_BIT     = 4;
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_STATE_LSB = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [VAL_W-1:0]    TIMEBASE_RST  = 14'h0001;
  localparam logic [STEP_W-1:0]   LAST_STEP_RST = 5'h10;
  localparam logic [STEP_W-1:0]   PRESET_RST    = 5'h01;
  localparam logic [NUM_OUTS-1:0] OUT_MASK_RST  = 16'hFFFF;
  localparam logic [5:0]          BASE_CTR_RST  = 6'h00;

  typedef enum logic [1:0] {
    ST_PROG = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } seq_state_t;

endpackage

// file: event_step_sequencer.sv
// event step sequencer: sixteen steps, timed and event transitions, register port
//
// Function
// - sixteen steps, each holding a state for all sixteen outputs.
// - one output mapping shared by all steps; each step has its own pattern.
// - one shared timebase, 0.01 s to 99.99 s per tick.
// - timed dwell equals 0.01 s times timebase times the step's count.
// - timebase and per-step count accept values up to 9999.
// - on count expiry move to the next step and drive its pattern at once.
// - sequencer evaluated exactly once per controller scan.
// - with event and count, hold while event false, count only while true.
// - each step independently uses event, time, or both.
// - fewer steps and outputs may be used; last step may be any number.
// - four consecutive counter words from a base; base status bit flags completion. The words sit at fixed offsets 0x10 to 0x1C whatever base_ctr_r holds.
// - words are step count, tick timer, preset step, current step.
// - preset word changes only on program write or reconfigure and restart.
// - last step met sets done bit, enters completed state holding last pattern.
// - completed state ignores start and jog.
// - reset or run entry leaves completion, clears bit; reset or non-retentive run entry enters preset step.
// - reset off and start on runs; start off freezes state and outputs.
// - each jog rising edge advances one step when reset is inactive.
// - reset beats start and holds the sequencer in the preset step.
// - preset step is 1 to 16, entered on reset and non-retentive run entry.
// - base counter chosen among 64 counters; the next three follow it.
// - outputs driven whenever run mode is on, from the current step.
// - non-retentive run entry clears count, timer, loads preset; retentive keeps.
// - jog advance zeroes the step timer; new step runs at once if started.
//
// The register addresses and the strobed register port are this design's own decisions.
module event_step_sequencer #(
  parameter int TICK_CYC = event_step_sequencer_pkg::TICK_CYCLES,
  parameter int SCAN_CYC = event_step_sequencer_pkg::SCAN_CYCLES
) (
  // clock and reset
  input  wire logic                                         clk_in,
  input  wire logic                                         nrst_in,
  // register port
  input  wire logic [event_step_sequencer_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [event_step_sequencer_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic                                         wr_in,
  input  wire logic                                         rd_in,
  output logic      [event_step_sequencer_pkg::DATA_W-1:0]  rdata_out,
  // control program inputs
  input  wire logic                                         start_in,
  input  wire logic                                         jog_in,
  input  wire logic                                         seq_reset_in,
  input  wire logic [event_step_sequencer_pkg::NUM_OUTS-1:0] step_event_input_in,
  // sequencer outputs
  output logic      [event_step_sequencer_pkg::NUM_OUTS-1:0] step_out_out,
  output logic                                              cycle_done_bit_out,
  output logic      [event_step_sequencer_pkg::STEP_W-1:0]  current_step_out
);
  import event_step_sequencer_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam int SCAN_W = $clog2(SCAN_CYC + 1);

  if (TICK_CYC < 1 || SCAN_CYC < 1) begin : g_bad_param
    $error("tick and scan cycle counts must be at least one");
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [3:0] step_idx(input logic [STEP_W-1:0] s);
    logic [STEP_W-1:0] t;
    t = s - 5'h01;
    return t[3:0];
  endfunction

  function automatic logic valid_step(input logic [STEP_W-1:0] s);
    return (s >= 5'h01) && (s <= 5'h10);
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [VAL_W-1:0]    count_mem [NUM_STEPS];
  logic [NUM_OUTS-1:0] pattern_mem [NUM_STEPS];
  logic [4:0]          event_mem [NUM_STEPS];
  logic                run_mode_r;
  logic                retentive_r;
  logic                run_prev_r;
  logic [VAL_W-1:0]    timebase_r;
  logic [STEP_W-1:0]   last_step_r;
  logic [NUM_OUTS-1:0] out_mask_r;
  logic [5:0]          base_ctr_r;
  logic [STEP_W-1:0]   preset_r;
  logic [STEP_W-1:0]   cur_r;
  logic [STEP_W-1:0]   cur_nxt;
  logic [VAL_W-1:0]    cnt_r;
  logic [VAL_W-1:0]    cnt_nxt;
  logic [VAL_W-1:0]    tmr_r;
  logic [VAL_W-1:0]    tmr_nxt;
  logic                done_r;
  logic                done_nxt;
  seq_state_t          state_r;
  seq_state_t          state_nxt;
  logic                jog_seen_r;
  logic                tick_pend_r;
  logic [TICK_W-1:0]   tick_cnt_r;
  logic [SCAN_W-1:0]   scan_cnt_r;
  logic                scan_r;
  logic [DATA_W-1:0]   rdata_nxt;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [NUM_OUTS+2:0] sync1_r;
  logic [NUM_OUTS+2:0] sync2_r;
  logic                start_s;
  logic                jog_s;
  logic                rst_s;
  logic [NUM_OUTS-1:0] event_s;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {start_in, jog_in, seq_reset_in, step_event_input_in};
      sync2_r <= sync1_r;
    end
  end

  assign start_s = sync2_r[NUM_OUTS+2];
  assign jog_s   = sync2_r[NUM_OUTS+1];
  assign rst_s   = sync2_r[NUM_OUTS];
  assign event_s = sync2_r[NUM_OUTS-1:0];

  // ---------------------------------------------------------------
  // scan strobe and 0.01 s tick
  // ---------------------------------------------------------------
  wire scan_wrap = (scan_cnt_r == SCAN_W'(SCAN_CYC - 1));
  wire tick_wrap = (tick_cnt_r == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scan_cnt_r  <= '0;
      scan_r      <= 1'b0;
      tick_cnt_r  <= '0;
      tick_pend_r <= 1'b0;
    end else begin
      scan_cnt_r  <= scan_wrap ? '0 : scan_cnt_r + SCAN_W'(1);
      scan_r      <= scan_wrap;
      tick_cnt_r  <= (tick_wrap || !run_mode_r) ? '0 : tick_cnt_r + TICK_W'(1);
      // a tick landing on the consuming scan is kept
      tick_pend_r <= (tick_wrap && run_mode_r) || (tick_pend_r && !scan_r);
    end
  end

  // ---------------------------------------------------------------
  // current step decode
  // ---------------------------------------------------------------
  wire [3:0]          idx        = step_idx(cur_r);
  wire [VAL_W-1:0]    cnt_prog   = count_mem[idx];
  wire [4:0]          evt_cfg    = event_mem[idx];
  wire                use_evt    = evt_cfg[EVT_EN_BIT];
  wire                evt_ok     = !use_evt || event_s[evt_cfg[3:0]];
  wire [VAL_W-1:0]    tb_eff     = (timebase_r == '0) ? VAL_W'(1) : timebase_r;
  wire                jog_edge   = jog_s && !jog_seen_r;
  wire                run_rise   = run_mode_r && !run_prev_r;
  wire                at_last    = (cur_r >= last_step_r);
  wire                tmr_expire = (tmr_r + VAL_W'(1)) >= tb_eff;
  wire                cnt_expire = (cnt_r + VAL_W'(1)) >= cnt_prog;
  wire [NUM_OUTS-1:0] pattern_sel = pattern_mem[idx] & out_mask_r;

  // ---------------------------------------------------------------
  // step sequencing
  // ---------------------------------------------------------------
  always_comb begin
    logic advance;
    advance   = 1'b0;
    cur_nxt   = cur_r;
    cnt_nxt   = cnt_r;
    tmr_nxt   = tmr_r;
    done_nxt  = done_r;
    state_nxt = state_r;
    if (!run_mode_r) begin
      state_nxt = ST_PROG;
    end else if (run_rise) begin
      state_nxt = ST_RUN;
      done_nxt  = 1'b0;
      if (!retentive_r || state_r == ST_DONE) begin
        cur_nxt = preset_r;
        cnt_nxt = '0;
        tmr_nxt = '0;
      end
    end else if (scan_r) begin
      if (rst_s) begin
        state_nxt = ST_RUN;
        done_nxt  = 1'b0;
        cur_nxt   = preset_r;
        cnt_nxt   = '0;
        tmr_nxt   = '0;
      end else if (state_r == ST_RUN) begin
        if (jog_edge) begin
          advance = 1'b1;
        end else if (start_s && evt_ok) begin
          if (cnt_prog == '0) begin
            advance = 1'b1;
          end else if (tick_pend_r) begin
            if (!tmr_expire) begin
              tmr_nxt = tmr_r + VAL_W'(1);
            end else if (cnt_expire) begin
              advance = 1'b1;
            end else begin
              tmr_nxt = '0;
              cnt_nxt = cnt_r + VAL_W'(1);
            end
          end
        end
      end
    end
    if (advance) begin
      tmr_nxt = '0;
      cnt_nxt = '0;
      if (at_last) begin
        state_nxt = ST_DONE;
        done_nxt  = 1'b1;
      end else begin
        cur_nxt = cur_r + STEP_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r    <= ST_PROG;
      cur_r      <= PRESET_RST;
      cnt_r      <= '0;
      tmr_r      <= '0;
      done_r     <= 1'b0;
      run_prev_r <= 1'b0;
      jog_seen_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cur_r      <= cur_nxt;
      cnt_r      <= cnt_nxt;
      tmr_r      <= tmr_nxt;
      done_r     <= done_nxt;
      run_prev_r <= run_mode_r;
      jog_seen_r <= scan_r ? jog_s : jog_seen_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step_out_out       <= '0;
      cycle_done_bit_out <= 1'b0;
      current_step_out   <= PRESET_RST;
    end else begin
      step_out_out       <= run_mode_r ? pattern_sel : '0;
      cycle_done_bit_out <= done_r;
      current_step_out   <= cur_r;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  wire [1:0] area     = addr_in[7:6];
  wire [3:0] area_idx = addr_in[5:2];
  wire       aligned  = (addr_in[1:0] == 2'b00);
  wire [VAL_W-1:0]  wr_val  = wdata_in[VAL_W-1:0];
  wire [STEP_W-1:0] wr_step = wdata_in[STEP_W-1:0];
  wire       wr_val_ok = (wdata_in[31:VAL_W] == '0) && (wr_val <= VAL_W'(MAX_SETTING));

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_mode_r  <= 1'b0;
      retentive_r <= 1'b1;
      timebase_r  <= TIMEBASE_RST;
      last_step_r <= LAST_STEP_RST;
      out_mask_r  <= OUT_MASK_RST;
      base_ctr_r  <= BASE_CTR_RST;
      preset_r    <= PRESET_RST;
    end else if (wr_in && aligned) begin
      if (addr_in == ADDR_CTRL) begin
        run_mode_r  <= wdata_in[CTRL_RUN_BIT];
        retentive_r <= wdata_in[CTRL_RET_BIT];
      end else if (addr_in == ADDR_TIMEBASE && wr_val_ok) begin
        timebase_r <= wr_val;
      end else if (addr_in == ADDR_LAST_STEP && valid_step(wr_step)) begin
        last_step_r <= wr_step;
      end else if (addr_in == ADDR_OUT_MASK) begin
        out_mask_r <= wdata_in[NUM_OUTS-1:0];
      end else if (addr_in == ADDR_BASE_CTR) begin
        base_ctr_r <= wdata_in[5:0];
      end else if (addr_in == ADDR_PRESET && valid_step(wr_step)) begin
        preset_r <= wr_step;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_STEPS; i++) begin
        count_mem[i]   <= '0;
        pattern_mem[i] <= '0;
        event_mem[i]   <= '0;
      end
    end else if (wr_in && aligned) begin
      if (area == AREA_COUNTS && wr_val_ok) begin
        count_mem[area_idx] <= wr_val;
      end else if (area == AREA_PATTERN) begin
        pattern_mem[area_idx] <= wdata_in[NUM_OUTS-1:0];
      end else if (area == AREA_EVENT) begin
        event_mem[area_idx] <= wdata_in[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    if (!rd_in || !aligned) begin
      rdata_nxt = '0;
    end else if (addr_in == ADDR_CTRL) begin
      rdata_nxt[CTRL_RUN_BIT] = run_mode_r;
      rdata_nxt[CTRL_RET_BIT] = retentive_r;
    end else if (addr_in == ADDR_TIMEBASE) begin
      rdata_nxt[VAL_W-1:0] = timebase_r;
    end else if (addr_in == ADDR_LAST_STEP) begin
      rdata_nxt[STEP_W-1:0] = last_step_r;
    end else if (addr_in == ADDR_OUT_MASK) begin
      rdata_nxt[NUM_OUTS-1:0] = out_mask_r;
    end else if (addr_in == ADDR_STEP_CNT) begin
      rdata_nxt[VAL_W-1:0] = cnt_r;
    end else if (addr_in == ADDR_TICK_TMR) begin
      rdata_nxt[VAL_W-1:0] = tmr_r;
    end else if (addr_in == ADDR_PRESET) begin
      rdata_nxt[STEP_W-1:0] = preset_r;
    end else if (addr_in == ADDR_CUR_STEP) begin
      rdata_nxt[STEP_W-1:0] = cur_r;
    end else if (addr_in == ADDR_STATUS) begin
      rdata_nxt[STAT_DONE_BIT] = done_r;
      rdata_nxt[STAT_STATE_LSB+1:STAT_STATE_LSB] = state_r;
    end else if (addr_in == ADDR_BASE_CTR) begin
      rdata_nxt[5:0] = base_ctr_r;
    end else if (area == AREA_COUNTS) begin
      rdata_nxt[VAL_W-1:0] = count_mem[area_idx];
    end else if (area == AREA_PATTERN) begin
      rdata_nxt[NUM_OUTS-1:0] = pattern_mem[area_idx];
    end else if (area == AREA_EVENT) begin
      rdata_nxt[4:0] = event_mem[area_idx];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence scan_live_s;
    scan_r && run_mode_r && !run_rise;
  endsequence

  sequence run_quiet_s;
    scan_live_s and (state_r == ST_RUN && !rst_s && !jog_edge);
  endsequence

  reset_hold_a: assert property (scan_live_s and rst_s |=> cur_r == preset_r && cnt_r == '0 && tmr_r == '0)
    else $error("reset did not hold preset step");

  done_ignore_a: assert property (scan_live_s and (state_r == ST_DONE && !rst_s) |=> state_r == ST_DONE)
    else $error("completed state left without reset");

  done_bit_a: assert property (state_r == ST_RUN ##1 state_r == ST_DONE |=> cycle_done_bit_out)
    else $error("done bit not raised after completion");

  freeze_a: assert property (run_quiet_s and !start_s |=> $stable(cur_r) && $stable(tmr_r) && $stable(cnt_r))
    else $error("sequencer moved while start off");

  evt_hold_a: assert property (run_quiet_s and (use_evt && !evt_ok) |=> $stable(cur_r) && $stable(tmr_r))
    else $error("event step moved with event false");

  jog_adv_a: assert property (scan_live_s and (state_r == ST_RUN && !rst_s && jog_edge && !at_last)
                              |=> cur_r == $past(cur_r) + 5'h01 && tmr_r == '0)
    else $error("jog did not advance one step");

  out_follow_a: assert property (run_mode_r |=> step_out_out == $past(pattern_sel))
    else $error("outputs not showing current pattern");

  preset_stable_a: assert property (!(wr_in && addr_in == ADDR_PRESET) |=> $stable(preset_r))
    else $error("preset changed without a write");

  run_entry_a: assert property (run_rise && !retentive_r |=> cur_r == $past(preset_r) && cnt_r == '0 && !done_r)
    else $error("run entry did not initialise");

  preset_range_a: assert property (valid_step(preset_r) && valid_step(cur_r))
    else $error("step number out of range");

endmodule

// file: seq_ctl_model.sv
// control program model driving start, jog, reset and event levels
module seq_ctl_model #(
  parameter int SCAN_CYC = 4
) (
  // clock
  input  wire logic        clk_in,
  // control levels
  output logic             start_out,
  output logic             jog_out,
  output logic             rst_out,
  output logic [15:0]      evt_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    start_out = 1'b0;
    jog_out   = 1'b0;
    rst_out   = 1'b0;
    evt_out   = 16'h0000;
  end

  // levels change after an edge and stand for three scans
  task automatic drive(input logic s, input logic r, input logic [15:0] e);
    @(posedge clk_in);
    start_out <= s;
    rst_out   <= r;
    evt_out   <= e;
    repeat (3 * SCAN_CYC) @(posedge clk_in);
    #1;
  endtask

  task automatic jog();
    @(posedge clk_in);
    jog_out <= 1'b1;
    repeat (3 * SCAN_CYC) @(posedge clk_in);
    jog_out <= 1'b0;
    repeat (3 * SCAN_CYC) @(posedge clk_in);
    #1;
  endtask
endmodule

// file: test_event_step_sequencer.sv
// self-checking bench of the event step sequencer
module test_event_step_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import event_step_sequencer_pkg::*;
  localparam int SCAN = 4;
  logic                clk_in;
  logic                nrst_in;
  logic                wr_in;
  logic                rd_in;
  logic [ADDR_W-1:0]   addr_in;
  logic [DATA_W-1:0]   wdata_in;
  logic [DATA_W-1:0]   rdata_out;
  logic                start_in;
  logic                jog_in;
  logic                seq_reset_in;
  logic                cycle_done_bit_out;
  logic [NUM_OUTS-1:0] step_event_input_in;
  logic [NUM_OUTS-1:0] step_out_out;
  logic [STEP_W-1:0]   current_step_out;
  int                  bad_count = 0;
  int                  checked = 0;
  int                  cycles = 0;

  event_step_sequencer #(.TICK_CYC(20), .SCAN_CYC(SCAN)) u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .start_in(start_in),
    .jog_in(jog_in), .seq_reset_in(seq_reset_in), .step_event_input_in(step_event_input_in),
    .step_out_out(step_out_out), .cycle_done_bit_out(cycle_done_bit_out),
    .current_step_out(current_step_out));

  seq_ctl_model #(.SCAN_CYC(SCAN)) u_ctl (
    .clk_in(clk_in), .start_out(start_in), .jog_out(jog_in),
    .rst_out(seq_reset_in), .evt_out(step_event_input_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic give_verdict();
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    chk(what, exp, rdata_out);
  endtask

  // step s reached, or done bit set when s is zero; bounded
  task automatic wait_step(input logic [4:0] s, input int lim);
    int n;
    n = 0;
    while (!(s == 5'd0 ? cycle_done_bit_out === 1'b1 : current_step_out === s) && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  initial begin
    nrst_in  = 1'b0;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    addr_in  = 8'h00;
    wdata_in = 32'h0000_0000;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_chk("ctrl", ADDR_CTRL, 32'h0000_0002);
    rd_chk("timebase", ADDR_TIMEBASE, 32'h0000_0001);
    rd_chk("last step", ADDR_LAST_STEP, 32'h0000_0010);
    rd_chk("mask", ADDR_OUT_MASK, 32'h0000_FFFF);
    rd_chk("preset", ADDR_PRESET, 32'h0000_0001);
    rd_chk("current", ADDR_CUR_STEP, 32'h0000_0001);
    rd_chk("status", ADDR_STATUS, 32'h0000_0000);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    wr(ADDR_BASE_CTR, 32'h0000_003F);
    rd_chk("base counter", ADDR_BASE_CTR, 32'h0000_003F);
    wr(ADDR_TIMEBASE, 32'd10000);
    wr(ADDR_PRESET, 32'd17);
    wr(ADDR_PRESET, 32'd0);
    rd_chk("preset", ADDR_PRESET, 32'h0000_0001);
    wr(ADDR_TIMEBASE, 32'd9999);
    rd_chk("timebase", ADDR_TIMEBASE, 32'h0000_270F);
    wr(ADDR_TIMEBASE, 32'd2);
    wr(ADDR_LAST_STEP, 32'd3);
    wr(ADDR_OUT_MASK, 32'h0000_7FFF);
    wr(8'h80, 32'h0000_00A5);
    wr(8'hC0, 32'h0000_0012);
    wr(8'h44, 32'd3);
    wr(8'h84, 32'h0000_DA00);
    wr(8'h48, 32'd1);
    wr(8'h88, 32'h0000_0F0F);
    wr(8'hC8, 32'h0000_0015);
    wr(ADDR_CTRL, 32'h0000_0001);
    u_ctl.drive(1'b0, 1'b0, 16'h0004);
    chk("stopped step", 32'd1, current_step_out);
    chk("run pattern", 32'h0000_00A5, step_out_out);
    u_ctl.drive(1'b1, 1'b0, 16'h0000);
    chk("no event", 32'd1, current_step_out);
    u_ctl.drive(1'b1, 1'b0, 16'h0004);
    wait_step(5'd2, 40);
    chk("event step", 32'd2, current_step_out);
    chk("step2 pattern", 32'h0000_5A00, step_out_out);
    repeat (70) @(posedge clk_in);
    #1;
    chk("dwell", 32'd2, current_step_out);
    wait_step(5'd3, 100);
    chk("timed advance", 32'd3, current_step_out);
    repeat (60) @(posedge clk_in);
    #1;
    chk("event held", 32'd3, current_step_out);
    u_ctl.drive(1'b1, 1'b0, 16'h0020);
    wait_step(5'd0, 100);
    chk("done bit", 32'd1, cycle_done_bit_out);
    chk("done pattern", 32'h0000_0F0F, step_out_out);
    rd_chk("status", ADDR_STATUS, 32'h0000_0007);
    u_ctl.jog();
    chk("done jog", 32'd3, current_step_out);
    u_ctl.drive(1'b1, 1'b1, 16'h0004);
    repeat (20) @(posedge clk_in);
    #1;
    chk("reset done", 32'd0, cycle_done_bit_out);
    chk("reset step", 32'd1, current_step_out);
    u_ctl.drive(1'b0, 1'b0, 16'h0000);
    u_ctl.jog();
    chk("jog step", 32'd2, current_step_out);
    rd_chk("tick timer", ADDR_TICK_TMR, 32'h0000_0000);
    rd_chk("step count", ADDR_STEP_CNT, 32'h0000_0000);
    rd_chk("preset kept", ADDR_PRESET, 32'h0000_0001);
    repeat (150) @(posedge clk_in);
    #1;
    chk("frozen", 32'd2, current_step_out);
    wr(ADDR_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk_in);
    #1;
    chk("program out", 32'h0000_0000, step_out_out);
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_step(5'd1, 20);
    chk("run entry", 32'd1, current_step_out);
    chk("entry pattern", 32'h0000_00A5, step_out_out);
    give_verdict();
  end
endmodule
